//--- rtl/mdu_pkg.sv
// constants, register map and timing for the dac update control block
// assumes a 100 MHz core clock and a plain register port with 32-bit data
package mdu_pkg;
  localparam int NCH = 32;
  localparam int DW = 12;
  localparam int FRAME_BITS = 24;
  localparam int QDEPTH = 128;
  localparam int QDEPTH_OFF = 2;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_TIME_US = 270;
  localparam int CLEAR_TIME_US = 32;
  localparam int CLEAR_CYCLES = CLEAR_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int CALC_CYCLES = 8;
  localparam logic [11:0] GAIN_RST = 12'hFFF;
  localparam logic [11:0] OFFS_RST = 12'h000;
  localparam logic [11:0] DAC_RST = 12'h000;
  localparam logic [11:0] CLRCODE_RST = 12'h000;
  // frame field positions
  localparam int F_AB = 23;
  localparam int F_RW = 22;
  // bit 21 is a fixed zero between r/w and the channel, bits 1:0 are ignored
  localparam int F_CH_HI = 20;
  localparam int F_CH_LO = 16;
  localparam int F_REG_HI = 15;
  localparam int F_REG_LO = 14;
  localparam int F_DAT_HI = 13;
  localparam int F_DAT_LO = 2;
  localparam logic [1:0] SEL_INPUT = 2'h3;
  localparam logic [1:0] SEL_OFFSET = 2'h2;
  localparam logic [1:0] SEL_GAIN = 2'h1;
  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CLRCODE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CHSEL = 8'h0C;
  localparam logic [7:0] ADDR_CHDAC = 8'h10;
  localparam int CTRL_PD = 0;
  localparam int CTRL_LOAD = 1;
  localparam int CTRL_TOG_LO = 2;
  localparam int CTRL_TOG_HI = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;
endpackage

//--- rtl/mdu_top.sv
// dac update control: soft reset, clear, busy, load strobe, queue, serial frames
// assumes pins are asynchronous to core_clk and the serial clock is slow enough to sample
//
// The placing of the registers and the strobed register port were left to the implementer.
module mdu_top #(
  parameter int RESET_CYCLES = mdu_pkg::RESET_TIME_US * 1000 / mdu_pkg::CLK_PERIOD_NS
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic softResetN,
  input wire logic clearToCodeInputN,
  input wire logic outputLoadStrobeN,
  input wire logic queueEnable,
  input wire logic serialParallelSelect,
  input wire logic protocolSelect,
  input wire logic chainEnable,
  input wire logic frameSelectN,
  input wire logic serialClk,
  input wire logic serialDataIn,
  input wire logic parallelWriteN,
  input wire logic [23:0] parallelWord,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  output logic busyN,
  output logic outputHiZ,
  output logic outputLoad100k,
  output logic [mdu_pkg::NCH-1:0][11:0] dacCodes
);
  logic [1:0] rstSync_r;
  logic rstn;
  logic [1:0] s0_r, s1_r;
  logic [2:0] m1_r, m2_r;
  logic [5:0] p1_r, p2_r, pd_r;
  logic [23:0] pw1_r, pw2_r;
  logic srstFall, clrFall, ldacFall, ldacLow, fsFall, fsRise, sckFall, parFall;
  logic [31:0] seqCnt_r;
  logic seqActive, puSeq_r, seqStart;
  logic [12:0] clrCnt_r;
  logic clearActive, clearStart;
  logic queueOn_r;
  logic [5:0] ctrl_r;
  logic [11:0] clrCode_r;
  logic [4:0] chSel_r;
  logic [23:0] shift_r;
  logic [4:0] bitCnt_r;
  logic armed_r, serMode, serPush;
  logic [23:0] qMem [mdu_pkg::QDEPTH];
  logic [6:0] qRd_r, qWr_r;
  logic [7:0] qCount_r, qCap;
  logic push, pop, qFull;
  logic [23:0] pushWord, popWord;
  logic [3:0] calcCnt_r;
  logic calcActive, engineBusy, engBusyPrev_r, busyRise, ldacPending_r, loadNow;
  logic [4:0] calcCh_r;
  logic calcB_r;
  logic [11:0] inA [mdu_pkg::NCH];
  logic [11:0] inB [mdu_pkg::NCH];
  logic [11:0] gain [mdu_pkg::NCH];
  logic [11:0] offs [mdu_pkg::NCH];
  logic [11:0] calA [mdu_pkg::NCH];
  logic [11:0] calB [mdu_pkg::NCH];
  logic [mdu_pkg::NCH-1:0] changed_r, togSel_r;

  function automatic logic [11:0] calib(input logic [11:0] x, input logic [11:0] m,
                                        input logic [11:0] c);
    logic [24:0] prod;
    logic [13:0] sum;
    prod = 25'(x) * 25'({1'b0, m} + 13'h1);
    sum = 14'(prod[24:12]) + 14'(c);
    return (sum > 14'h0FFF) ? 12'hFFF : sum[11:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) rstSync_r <= 2'h0;
    else rstSync_r <= {rstSync_r[0], 1'b1};
  end
  assign rstn = rstSync_r[1];

  // s0/s1 and p1/p2 first and second stage, pd a delayed copy of p2 for edges
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      p1_r <= 6'h3F;
      p2_r <= 6'h3F;
      pd_r <= 6'h3F;
      s0_r <= 2'h0;
      s1_r <= 2'h0;
      m1_r <= 3'h0;
      m2_r <= 3'h0;
      pw1_r <= 24'h000000;
      pw2_r <= 24'h000000;
    end else begin
      p1_r <= {softResetN, clearToCodeInputN, outputLoadStrobeN, frameSelectN,
               serialClk, parallelWriteN};
      p2_r <= p1_r;
      pd_r <= p2_r;
      s0_r <= {serialDataIn, queueEnable};
      s1_r <= s0_r;
      m1_r <= {serialParallelSelect, protocolSelect, chainEnable};
      m2_r <= m1_r;
      pw1_r <= parallelWord;
      pw2_r <= pw1_r;
    end
  end
  assign srstFall = pd_r[5] && !p2_r[5];
  assign clrFall = pd_r[4] && !p2_r[4];
  assign ldacFall = pd_r[3] && !p2_r[3];
  assign ldacLow = !p2_r[3];
  assign fsFall = pd_r[2] && !p2_r[2];
  assign fsRise = !pd_r[2] && p2_r[2];
  assign sckFall = pd_r[1] && !p2_r[1];
  assign parFall = pd_r[0] && !p2_r[0];
  // mode straps get two stages too; a mode change in mid-frame is not supported
  assign serMode = m2_r[2] && !m2_r[1] && !m2_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // power-up and soft reset sequence
  // only the edge counts, so a reset pin held low does not lock the part
  assign seqStart = srstFall && !seqActive;
  assign seqActive = seqCnt_r != 32'h0;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      seqCnt_r <= 32'(RESET_CYCLES);
      puSeq_r <= 1'b1;
    end else if (seqStart) begin
      seqCnt_r <= 32'(RESET_CYCLES);
    end else if (seqActive) begin
      seqCnt_r <= seqCnt_r + 32'hFFFFFFFF;
      if (seqCnt_r == 32'h1) puSeq_r <= 1'b0;
    end
  end

  // clear: triggered by the falling edge; a held level does not retrigger
  assign clearStart = clrFall && !seqActive && !clearActive;
  assign clearActive = clrCnt_r != 13'h0;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) clrCnt_r <= 13'h0;
    else if (seqStart) clrCnt_r <= 13'h0;
    else if (clearStart) clrCnt_r <= 13'(mdu_pkg::CLEAR_CYCLES);
    else if (clearActive) clrCnt_r <= clrCnt_r - 13'h1;
  end

  // queue enable sampled as each sequence or clear finishes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) queueOn_r <= 1'b0;
    else if ((seqCnt_r == 32'h1) || (clrCnt_r == 13'h1)) begin
      queueOn_r <= s1_r[0] && !m2_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= mdu_pkg::CTRL_RST;
      clrCode_r <= mdu_pkg::CLRCODE_RST;
      chSel_r <= 5'h00;
    end else if (regWrite) begin
      unique case (regAddr)
        mdu_pkg::ADDR_CTRL: ctrl_r <= regWdata[5:0];
        mdu_pkg::ADDR_CLRCODE: clrCode_r <= regWdata[11:0];
        mdu_pkg::ADDR_CHSEL: chSel_r <= regWdata[4:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) regRdata <= 32'h00000000;
    else if (regRead) begin
      unique case (regAddr)
        mdu_pkg::ADDR_CTRL: regRdata <= {26'h0, ctrl_r};
        mdu_pkg::ADDR_CLRCODE: regRdata <= {20'h0, clrCode_r};
        mdu_pkg::ADDR_STATUS: regRdata <= {21'h0, qCount_r, qFull, queueOn_r, busyN};
        mdu_pkg::ADDR_CHSEL: regRdata <= {27'h0, chSel_r};
        mdu_pkg::ADDR_CHDAC: regRdata <= {20'h0, dacCodes[chSel_r]};
        default: regRdata <= 32'h00000000;
      endcase
    end else regRdata <= 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // standalone serial receiver
  assign serPush = serMode && fsRise && armed_r && (bitCnt_r == 5'd24);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bitCnt_r <= 5'h00;
      armed_r <= 1'b0;
      shift_r <= 24'h000000;
    end else if (seqActive || !serMode) begin
      armed_r <= 1'b0;
    end else if (fsFall) begin
      bitCnt_r <= 5'h00;
      armed_r <= 1'b1;
    end else if (fsRise) begin
      armed_r <= 1'b0;
    end else if (sckFall && !p2_r[2] && armed_r && (bitCnt_r != 5'd24)) begin
      shift_r <= {shift_r[22:0], s1_r[1]};
      bitCnt_r <= bitCnt_r + 5'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction queue; without queue mode depth is cut to two
  assign qCap = (queueOn_r && !m2_r[2]) ? 8'(mdu_pkg::QDEPTH) : 8'(mdu_pkg::QDEPTH_OFF);
  assign qFull = qCount_r >= qCap;
  assign pushWord = serMode ? shift_r : pw2_r;
  assign push = !seqActive && (serPush || (!m2_r[2] && parFall)) && !qFull;
  assign pop = (qCount_r != 8'h0) && !calcActive && !clearActive && !seqActive;
  assign popWord = qMem[qRd_r];

  always_ff @(posedge core_clk) begin
    if (push) qMem[qWr_r] <= pushWord;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      qRd_r <= 7'h00;
      qWr_r <= 7'h00;
      qCount_r <= 8'h00;
    end else if (seqStart) begin
      qRd_r <= 7'h00;
      qWr_r <= 7'h00;
      qCount_r <= 8'h00;
    end else begin
      if (push) qWr_r <= qWr_r + 7'h1;
      if (pop) qRd_r <= qRd_r + 7'h1;
      qCount_r <= qCount_r + 8'(push) - 8'(pop);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // calibration engine and busy
  assign calcActive = calcCnt_r != 4'h0;
  assign engineBusy = calcActive || (qCount_r != 8'h0);
  assign busyRise = engBusyPrev_r && !engineBusy;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      calcCnt_r <= 4'h0;
      calcCh_r <= 5'h00;
      calcB_r <= 1'b0;
    end else if (seqStart) begin
      calcCnt_r <= 4'h0;
    end else if (pop && !popWord[mdu_pkg::F_RW] &&
                 (popWord[mdu_pkg::F_REG_HI:mdu_pkg::F_REG_LO] != 2'h0)) begin
      calcCnt_r <= 4'(mdu_pkg::CALC_CYCLES);
      calcCh_r <= popWord[mdu_pkg::F_CH_HI:mdu_pkg::F_CH_LO];
      calcB_r <= popWord[mdu_pkg::F_AB] &&
                 ctrl_r[mdu_pkg::CTRL_TOG_LO + 32'(popWord[mdu_pkg::F_CH_HI:mdu_pkg::F_CH_HI-1])];
    end else if (calcActive) begin
      calcCnt_r <= calcCnt_r - 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busyN <= 1'b0;
      engBusyPrev_r <= 1'b0;
      outputHiZ <= 1'b1;
      outputLoad100k <= 1'b0;
    end else begin
      busyN <= !(seqActive || engineBusy);
      engBusyPrev_r <= engineBusy;
      // power-down leaves every register untouched
      outputHiZ <= puSeq_r || (ctrl_r[mdu_pkg::CTRL_PD] && !ctrl_r[mdu_pkg::CTRL_LOAD]);
      outputLoad100k <= !puSeq_r && ctrl_r[mdu_pkg::CTRL_PD] && ctrl_r[mdu_pkg::CTRL_LOAD];
    end
  end

  // load strobe: stored while busy, discarded during reset
  assign loadNow = !seqActive && !clearActive && !engineBusy &&
                   (ldacPending_r || ldacFall || (ldacLow && busyRise));
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) ldacPending_r <= 1'b0;
    else if (seqActive) ldacPending_r <= 1'b0;
    else if (ldacFall && (engineBusy || clearActive)) ldacPending_r <= 1'b1;
    else if (loadNow) ldacPending_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel register file
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < mdu_pkg::NCH; i++) begin
        inA[i] <= mdu_pkg::DAC_RST;
        inB[i] <= mdu_pkg::DAC_RST;
        gain[i] <= mdu_pkg::GAIN_RST;
        offs[i] <= mdu_pkg::OFFS_RST;
        calA[i] <= mdu_pkg::DAC_RST;
        calB[i] <= mdu_pkg::DAC_RST;
        dacCodes[i] <= mdu_pkg::DAC_RST;
      end
      changed_r <= '0;
      togSel_r <= '0;
    end else if (seqStart) begin
      for (int i = 0; i < mdu_pkg::NCH; i++) begin
        inA[i] <= mdu_pkg::DAC_RST;
        inB[i] <= mdu_pkg::DAC_RST;
        gain[i] <= mdu_pkg::GAIN_RST;
        offs[i] <= mdu_pkg::OFFS_RST;
        calA[i] <= mdu_pkg::DAC_RST;
        calB[i] <= mdu_pkg::DAC_RST;
        dacCodes[i] <= mdu_pkg::DAC_RST;
      end
      changed_r <= '0;
      togSel_r <= '0;
    end else begin
      if (pop && !popWord[mdu_pkg::F_RW]) begin
        unique case (popWord[mdu_pkg::F_REG_HI:mdu_pkg::F_REG_LO])
          mdu_pkg::SEL_INPUT: begin
            if (popWord[mdu_pkg::F_AB])
              inB[popWord[mdu_pkg::F_CH_HI:mdu_pkg::F_CH_LO]] <=
                popWord[mdu_pkg::F_DAT_HI:mdu_pkg::F_DAT_LO];
            else
              inA[popWord[mdu_pkg::F_CH_HI:mdu_pkg::F_CH_LO]] <=
                popWord[mdu_pkg::F_DAT_HI:mdu_pkg::F_DAT_LO];
          end
          mdu_pkg::SEL_OFFSET: offs[popWord[mdu_pkg::F_CH_HI:mdu_pkg::F_CH_LO]] <=
                                 popWord[mdu_pkg::F_DAT_HI:mdu_pkg::F_DAT_LO];
          mdu_pkg::SEL_GAIN: gain[popWord[mdu_pkg::F_CH_HI:mdu_pkg::F_CH_LO]] <=
                               popWord[mdu_pkg::F_DAT_HI:mdu_pkg::F_DAT_LO];
          default: ;
        endcase
      end
      // result written on the last computing cycle
      if (calcCnt_r == 4'h1) begin
        if (calcB_r) calB[calcCh_r] <= calib(inB[calcCh_r], gain[calcCh_r], offs[calcCh_r]);
        else calA[calcCh_r] <= calib(inA[calcCh_r], gain[calcCh_r], offs[calcCh_r]);
      end
      if (clearStart) begin
        for (int i = 0; i < mdu_pkg::NCH; i++) dacCodes[i] <= clrCode_r;
      end else if (loadNow) begin
        for (int i = 0; i < mdu_pkg::NCH; i++) begin
          if (ctrl_r[mdu_pkg::CTRL_TOG_LO + i / 8]) begin
            dacCodes[i] <= togSel_r[i] ? calA[i] : calB[i];
          end else if (changed_r[i]) begin
            dacCodes[i] <= calA[i];
          end
        end
      end
      // a fresh result wins over the clear caused by a simultaneous load
      for (int i = 0; i < mdu_pkg::NCH; i++) begin
        changed_r[i] <= (changed_r[i] && !loadNow) ||
                        ((calcCnt_r == 4'h1) && (calcCh_r == 5'(i)));
        if (loadNow && ctrl_r[mdu_pkg::CTRL_TOG_LO + i / 8]) togSel_r[i] <= !togSel_r[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_reset_busy: assert property (seqStart |=> ##1 !busyN)
    else $error("busy not low during reset");
  chk_reset_len: assert property (seqCnt_r <= 32'(RESET_CYCLES))
    else $error("reset sequence too long");
  chk_reset_start: assert property (srstFall && !seqActive |=> seqActive)
    else $error("reset edge missed");
  chk_reset_value: assert property (seqStart |=> gain[0] == 12'hFFF && dacCodes[0] == 12'h000)
    else $error("reset values wrong");
  chk_output_load_strobe_drop: assert property (seqActive |=> !ldacPending_r)
    else $error("strobe kept during reset");
  chk_clear_load: assert property (clearStart |=> dacCodes[31] == $past(clrCode_r))
    else $error("clear code not loaded");
  chk_clear_len: assert property (clearStart |=> clrCnt_r == 13'd3200)
    else $error("clear time wrong");
  chk_calc_busy: assert property ($rose(calcActive) |=> !busyN [*2])
    else $error("busy high during computation");
  chk_no_load_busy: assert property (loadNow |-> !engineBusy && !seqActive)
    else $error("load while busy");
  chk_pend_apply: assert property (ldacPending_r && !engineBusy && !seqActive
                                   && !clearActive |-> loadNow)
    else $error("stored strobe not applied");
  chk_queue_full: assert property (qFull && !pop |=> qCount_r == $past(qCount_r))
    else $error("write taken while full");
  chk_bad_frame: assert property (fsRise && bitCnt_r != 5'd24 |-> !serPush)
    else $error("short frame accepted");
  chk_bit_count: assert property (bitCnt_r <= 5'd24)
    else $error("bit count overrun");
  chk_pu_float: assert property (puSeq_r |=> outputHiZ)
    else $error("outputs driven during power-up");

  cov_frame: cover property (serPush);
  cov_stored_load: cover property (ldacPending_r ##[1:400] loadNow);
  cov_soft_reset: cover property (seqStart);
  cov_clear: cover property (clearStart);
endmodule

//--- tb/mdu_host_model.sv
// host model: drives standalone serial frames into the update control block
// assumes the link timing is unrelated to the core clock
module mdu_host_model (
  output logic frameSelectN,
  output logic serialClk,
  output logic serialDataIn
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    frameSelectN = 1'b1;
    serialClk = 1'b1;
    serialDataIn = 1'b0;
  end
  ////////////////////////////////////////
  // nb clocks sent, msb first; clocks past bit 23 carry random filler
  task automatic sendFrame(input logic [23:0] fr, input int nb);
    // frame select rests high first, so back-to-back frames keep both edges
    #126;
    frameSelectN = 1'b0;
    #62.5;
    for (int i = 0; i < nb; i++) begin
      serialClk = 1'b1;
      serialDataIn = (i < 24) ? fr[23 - i] : 1'($urandom);
      #62.5;
      serialClk = 1'b0;
      #62.5;
    end
    // clock stands still high between frames
    serialClk = 1'b1;
    #62.5;
    frameSelectN = 1'b1;
    // released data line must not look like a held bit
    serialDataIn = ~serialDataIn;
  endtask
endmodule

//--- tb/mdu_top_tb_top.sv
// self-checking bench for mdu_top: frames, load strobe, clear, power-down, soft reset
// assumes mdu_host_model and the mdu_pkg constants
module mdu_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RC = 400; // short reset sequence, still longer than one frame
  logic core_clk = 1'b0, resetn = 1'b0, softResetN = 1'b1, clearToCodeInputN = 1'b1;
  logic outputLoadStrobeN = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [23:0] parallelWord = 24'h000000;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h00000000;
  logic [31:0] regRdata;
  logic busyN, outputHiZ, outputLoad100k, frameSelectN, serialClk, serialDataIn;
  logic [mdu_pkg::NCH-1:0][11:0] dacCodes;
  logic [11:0] gain [32], offs [32], inp [32], cal [32], dac [32];
  logic pend [32];
  int miscompares = 0, cmp_count = 0;
  initial forever #5 core_clk = ~core_clk;
  mdu_host_model mdu_host_model_inst (.frameSelectN(frameSelectN), .serialClk(serialClk),
    .serialDataIn(serialDataIn));
  // mode straps fixed to standalone serial
  mdu_top #(.RESET_CYCLES(RC)) mdu_top_inst (.core_clk(core_clk), .resetn(resetn),
    .softResetN(softResetN), .clearToCodeInputN(clearToCodeInputN),
    .outputLoadStrobeN(outputLoadStrobeN), .queueEnable(1'b0), .serialParallelSelect(1'b1),
    .protocolSelect(1'b0), .chainEnable(1'b0), .frameSelectN(frameSelectN),
    .serialClk(serialClk), .serialDataIn(serialDataIn), .parallelWriteN(1'b1),
    .parallelWord(parallelWord), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .busyN(busyN),
    .outputHiZ(outputHiZ), .outputLoad100k(outputLoad100k), .dacCodes(dacCodes));
  ////////////////////////////////////////
  task automatic chkBit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chkCode(input string nm, input logic [11:0] e, input logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkWord(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  function automatic logic [11:0] calib(input logic [11:0] x, m, c);
    int v;
    v = int'(x) * (int'(m) + 1) / 4096 + int'(c);
    return (v > 4095) ? 12'hFFF : v[11:0];
  endfunction
  function automatic logic [23:0] mkFrame(input logic [4:0] c, input logic [1:0] s,
    input logic [11:0] d);
    return {1'b0, 1'b0, 1'b0, c, s, d, 2'h0};
  endfunction
  task automatic mdlWrite(input logic [4:0] c, input logic [1:0] s, input logic [11:0] d);
    if (s == mdu_pkg::SEL_INPUT) inp[c] = d;
    else if (s == mdu_pkg::SEL_OFFSET) offs[c] = d;
    else gain[c] = d;
    cal[c] = calib(inp[c], gain[c], offs[c]);
    pend[c] = 1'b1;
  endtask
  task automatic mdlLoad(input logic rst);
    for (int i = 0; i < 32; i++) begin
      if (rst) begin
        gain[i] = 12'hFFF;
        offs[i] = 12'h000;
        inp[i] = 12'h000;
        cal[i] = 12'h000;
        dac[i] = 12'h000;
      end else if (pend[i]) dac[i] = cal[i];
      pend[i] = 1'b0;
    end
  endtask
  task automatic checkAll();
    for (int i = 0; i < 32; i++) chkCode("dacCodes", dac[i], dacCodes[i]);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task automatic regRd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic waitIdle();
    int n;
    n = 0;
    cyc(8);
    while (busyN !== 1'b1 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    chkBit("busyN idle", 1'b1, busyN);
  endtask
  task automatic strobe();
    @(posedge core_clk);
    outputLoadStrobeN <= 1'b0;
    cyc(3);
    outputLoadStrobeN <= 1'b1;
    cyc(8);
  endtask
  task automatic frame(input logic [4:0] c, input logic [1:0] s, input logic [11:0] d,
    input int nb);
    mdu_host_model_inst.sendFrame(mkFrame(c, s, d), nb);
    if (nb == 24 || nb > 24) mdlWrite(c, s, d);
  endtask
  ////////////////////////////////////////
  initial begin
    #500us;
    miscompares++;
    complete_run();
  end
  initial begin
    logic [31:0] rd;
    logic [1:0] sel;
    void'($urandom(8));
    mdlLoad(1'b1);
    cyc(2);
    resetn <= 1'b1;
    cyc(20);
    chkBit("busyN powerup", 1'b0, busyN);
    chkBit("outputHiZ powerup", 1'b1, outputHiZ);
    checkAll();
    waitIdle();
    chkBit("outputHiZ", 1'b0, outputHiZ);
    regRd(mdu_pkg::ADDR_CTRL, rd);
    chkWord("ctrl", 32'h00000000, rd);
    regRd(mdu_pkg::ADDR_STATUS, rd);
    chkWord("status", 32'h00000001, rd);
    regRd(8'h14, rd);
    chkWord("unmapped", 32'h00000000, rd);
    // odd passes strobe inside the busy window, even passes after it
    for (int k = 0; k < 16; k++) begin
      sel = (k < 2) ? mdu_pkg::SEL_INPUT : 2'(1 + $urandom % 3);
      parallelWord <= 24'($urandom);
      frame((k == 0) ? 5'h1F : 5'($urandom), sel, (k == 1) ? 12'hFFF : 12'($urandom), 24);
      if (k % 2) begin
        for (int n = 0; n < 10 && busyN !== 1'b0; n++) @(posedge core_clk);
        chkBit("busyN computing", 1'b0, busyN);
        checkAll();
        strobe();
        waitIdle();
        cyc(4);
      end else begin
        waitIdle();
        strobe();
      end
      mdlLoad(1'b0);
      checkAll();
    end
    frame(5'h03, mdu_pkg::SEL_INPUT, 12'hA5A, 20);
    frame(5'h04, mdu_pkg::SEL_INPUT, 12'h5A5, 30);
    waitIdle();
    strobe();
    mdlLoad(1'b0);
    checkAll();
    regWr(mdu_pkg::ADDR_CLRCODE, 32'h00000ABC);
    @(posedge core_clk);
    clearToCodeInputN <= 1'b0;
    cyc(6);
    clearToCodeInputN <= 1'b1;
    for (int i = 0; i < 32; i++) dac[i] = 12'hABC;
    checkAll();
    cyc(3300);
    frame(5'h05, mdu_pkg::SEL_INPUT, 12'h123, 24);
    waitIdle();
    strobe();
    mdlLoad(1'b0);
    checkAll();
    regWr(mdu_pkg::ADDR_CHSEL, 32'h00000005);
    regRd(mdu_pkg::ADDR_CHDAC, rd);
    chkWord("selected code", {20'h00000, dac[5]}, rd);
    regWr(mdu_pkg::ADDR_CTRL, 32'h00000001);
    cyc(2);
    chkBit("outputHiZ pd", 1'b1, outputHiZ);
    chkBit("outputLoad100k pd float", 1'b0, outputLoad100k);
    regWr(mdu_pkg::ADDR_CTRL, 32'h00000003);
    cyc(2);
    chkBit("outputLoad100k pd", 1'b1, outputLoad100k);
    chkBit("outputHiZ pd load", 1'b0, outputHiZ);
    checkAll();
    regWr(mdu_pkg::ADDR_CTRL, 32'h00000000);
    @(posedge core_clk);
    softResetN <= 1'b0;
    cyc(10);
    chkBit("busyN reset", 1'b0, busyN);
    mdu_host_model_inst.sendFrame(mkFrame(5'h06, mdu_pkg::SEL_INPUT, 12'h777), 24);
    strobe();
    chkBit("busyN reset", 1'b0, busyN);
    mdlLoad(1'b1);
    waitIdle();
    cyc(20);
    chkBit("busyN level held", 1'b1, busyN);
    softResetN <= 1'b1;
    strobe();
    checkAll();
    frame(5'h02, mdu_pkg::SEL_INPUT, 12'h300, 24);
    waitIdle();
    strobe();
    mdlLoad(1'b0);
    checkAll();
    // strobe held low: the load must follow the end of busy by itself
    @(posedge core_clk);
    outputLoadStrobeN <= 1'b0;
    cyc(8);
    frame(5'h07, mdu_pkg::SEL_INPUT, 12'(12'h456 ^ 12'($urandom)), 24);
    waitIdle();
    cyc(4);
    mdlLoad(1'b0);
    checkAll();
    outputLoadStrobeN <= 1'b1;
    complete_run();
  end
endmodule
